/* design/tss_pkg.sv */
package tss_pkg;
  localparam int          CLK_NS        = 20;
  localparam logic [3:0]  ADDR_PREFIX   = 4'h3;
  localparam logic [3:0]  PTR_CAP       = 4'h0;
  localparam logic [3:0]  PTR_CFG       = 4'h1;
  localparam logic [3:0]  PTR_UPPER     = 4'h2;
  localparam logic [3:0]  PTR_LOWER     = 4'h3;
  localparam logic [3:0]  PTR_CRIT      = 4'h4;
  localparam logic [3:0]  PTR_TEMP      = 4'h5;
  localparam logic [3:0]  PTR_MAKER     = 4'h6;
  localparam logic [3:0]  PTR_DEVID     = 4'h7;
  localparam logic [3:0]  PTR_RES       = 4'h8;
  localparam logic [15:0] LIMIT_MASK    = 16'h1FFC;
  localparam logic [15:0] CFG_MASK      = 16'h07FF;
  localparam int          CFG_EVT_EN    = 3;
  localparam logic [15:0] CFG_RST       = 16'h0000;
  localparam logic [15:0] LIMIT_RST     = 16'h0000;
  localparam logic [7:0]  RES_RST       = 8'h01;
  localparam logic [15:0] CAP_DEF       = 16'h000F;
  localparam logic [15:0] MAKER_ID_DEF  = 16'h00A5; // Arbitrary value
  localparam logic [15:0] DEV_ID_DEF    = 16'h5A01; // Arbitrary value
  localparam int          TA_CRIT_BIT   = 15;
  localparam int          TA_UPPER_BIT  = 14;
  localparam int          TA_LOWER_BIT  = 13;
  // Timing
  localparam int          BUS_IDLE_TIMEOUT_US = 25000;
  localparam int          BUS_IDLE_TIMEOUT_CYC_DEF  = BUS_IDLE_TIMEOUT_US * 1000 / CLK_NS;
  localparam int          BUS_FREE_NS   = 5000;
  localparam int          BUS_FREE_CYC  = (BUS_FREE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SCL_QTR_NS    = 2500;
  localparam int          QTR_CYC_DEF   = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;
  // Host register map
  localparam logic [7:0]  HR_CMD        = 8'h00;
  localparam logic [7:0]  HR_PTR        = 8'h04;
  localparam logic [7:0]  HR_WDATA      = 8'h08;
  localparam logic [7:0]  HR_STAT       = 8'h0C;
  localparam logic [7:0]  HR_RDATA      = 8'h10;
  localparam int          CMD_RW        = 7;
  localparam int          CMD_NB_LSB    = 8;
  localparam int          STAT_BUSY     = 0;
  localparam int          STAT_NACK     = 1;
  typedef enum logic [2:0] {
    DS_IDLE  = 3'b000,
    DS_RX    = 3'b001,
    DS_RXACK = 3'b010,
    DS_TX    = 3'b011,
    DS_TXACK = 3'b100
  } tss_dst_t;
  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_START = 3'b001,
    HS_BIT   = 3'b010,
    HS_STOP  = 3'b011,
    HS_FREE  = 3'b100
  } tss_hst_t;
endpackage : tss_pkg

/* design/tss_link_if.sv */
`timescale 1ns/1ns
interface tss_link_if;
  logic scl_o_h;
  logic scl_oe_h;
  logic sda_o_h;
  logic sda_oe_h;
  logic sda_o_d;
  logic sda_oe_d;
  logic evt_o_d;
  logic evt_oe_d;
  logic scl;
  logic sda;
  logic evt_n;
  // Pulled-up open-drain wires
  assign scl   = ~(scl_oe_h & ~scl_o_h);
  assign sda   = ~((sda_oe_h & ~sda_o_h) | (sda_oe_d & ~sda_o_d));
  assign evt_n = ~(evt_oe_d & ~evt_o_d);
  modport host (output scl_o_h, scl_oe_h, sda_o_h, sda_oe_h, input scl, sda);
  modport dev  (output sda_o_d, sda_oe_d, evt_o_d, evt_oe_d, input scl, sda);
endinterface : tss_link_if

/* design/tss_dev.sv */
// Register access over the serial link was chosen for this implementation.
`timescale 1ns/1ns
module tss_dev
  import tss_pkg::*;
#(
  parameter int unsigned  BUS_IDLE_TIMEOUT_CYC  = BUS_IDLE_TIMEOUT_CYC_DEF,
  parameter logic [15:0]  CAP_VAL   = CAP_DEF,
  parameter logic [15:0]  MAKER_ID  = MAKER_ID_DEF,
  parameter logic [15:0]  DEV_ID    = DEV_ID_DEF
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Serial link
  tss_link_if.dev          link,
  // Address straps
  input  wire logic        addr_sel_bit0,
  input  wire logic        addr_sel_bit1,
  input  wire logic        addr_sel_bit2,
  // Converter result
  input  wire logic        conv_done,
  input  wire logic [12:0] conv_temp
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0]  scl_s;
  logic [1:0]  sda_s;
  logic        scl_d;
  logic        sda_d;
  logic [2:0]  asel_s1;
  logic [2:0]  asel_s2;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_s   <= 2'h3;
      sda_s   <= 2'h3;
      scl_d   <= 1'b1;
      sda_d   <= 1'b1;
      asel_s1 <= 3'h0;
      asel_s2 <= 3'h0;
    end else begin
      scl_s   <= {scl_s[0], link.scl};
      sda_s   <= {sda_s[0], link.sda};
      scl_d   <= scl_s[1];
      sda_d   <= sda_s[1];
      asel_s1 <= {addr_sel_bit2, addr_sel_bit1, addr_sel_bit0};
      asel_s2 <= asel_s1;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_s[1] & ~scl_d;
  assign scl_fall  = ~scl_s[1] & scl_d;
  assign start_det = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  assign stop_det  = scl_s[1] & scl_d & ~sda_d & sda_s[1];

  // ----------------------------------------------------------------
  // Bus timeout
  // ----------------------------------------------------------------
  tss_dst_t    st_r;
  logic [31:0] tcnt_r;
  logic        bus_idle_timeout;

  assign bus_idle_timeout = (tcnt_r == 32'(BUS_IDLE_TIMEOUT_CYC));

  // Idle state is exempt, so a parked bus never trips it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tcnt_r <= 32'h0;
    end else if (scl_rise || scl_fall || st_r == DS_IDLE || bus_idle_timeout) begin
      tcnt_r <= 32'h0;
    end else begin
      tcnt_r <= tcnt_r + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [3:0]  ptr_r;
  logic [15:0] cfg_r;
  logic [15:0] upper_r;
  logic [15:0] lower_r;
  logic [15:0] crit_r;
  logic [15:0] temp_r;
  logic [7:0]  res_r;
  logic        wr_en_r;
  logic [15:0] wr_val_r;
  logic [15:0] rd_word;

  always_comb begin
    case (ptr_r)
      PTR_CAP:   rd_word = CAP_VAL;
      PTR_CFG:   rd_word = cfg_r;
      PTR_UPPER: rd_word = upper_r;
      PTR_LOWER: rd_word = lower_r;
      PTR_CRIT:  rd_word = crit_r;
      PTR_TEMP:  rd_word = temp_r;
      PTR_MAKER: rd_word = MAKER_ID;
      PTR_DEVID: rd_word = DEV_ID;
      PTR_RES:   rd_word = {8'h00, res_r};
      default:   rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r   <= CFG_RST;
      upper_r <= LIMIT_RST;
      lower_r <= LIMIT_RST;
      crit_r  <= LIMIT_RST;
      res_r   <= RES_RST;
    end else if (wr_en_r) begin
      case (ptr_r)
        PTR_CFG:   cfg_r   <= wr_val_r & CFG_MASK;
        PTR_UPPER: upper_r <= wr_val_r & LIMIT_MASK;
        PTR_LOWER: lower_r <= wr_val_r & LIMIT_MASK;
        PTR_CRIT:  crit_r  <= wr_val_r & LIMIT_MASK;
        PTR_RES:   res_r   <= wr_val_r[7:0];
        default:   res_r   <= res_r;
      endcase
    end
  end

  // Temperature and its comparator flags load together
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temp_r <= 16'h0000;
    end else if (conv_done) begin
      temp_r[12:0]         <= conv_temp;
      temp_r[TA_CRIT_BIT]  <= $signed(conv_temp) >= $signed(crit_r[12:0]);
      temp_r[TA_UPPER_BIT] <= $signed(conv_temp) > $signed(upper_r[12:0]);
      temp_r[TA_LOWER_BIT] <= $signed(conv_temp) < $signed(lower_r[12:0]);
    end
  end

  logic evt_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_r <= 1'b0;
    end else begin
      evt_r <= cfg_r[CFG_EVT_EN] & (|temp_r[15:13]);
    end
  end

  assign link.evt_o_d  = 1'b0;
  assign link.evt_oe_d = evt_r;

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  logic [3:0] cnt_r;
  logic [7:0] sr_r;
  logic [1:0] idx_r;
  logic       rw_r;
  logic       oe_r;
  logic [7:0] hi_r;
  logic       ack_ok;
  logic [7:0] nxt_byte;

  // Write bytes: address, pointer, then one or two data bytes
  assign ack_ok = (idx_r == 2'd1) || (idx_r == 2'd2) ||
                  (idx_r == 2'd3 && ptr_r != PTR_RES);

  // Read sends high then low byte; 8-bit register sends one
  always_comb begin
    if (ptr_r == PTR_RES) begin
      nxt_byte = (idx_r == 2'd0) ? rd_word[7:0] : 8'h00;
    end else if (idx_r == 2'd0) begin
      nxt_byte = rd_word[15:8];
    end else begin
      nxt_byte = (idx_r == 2'd1) ? rd_word[7:0] : 8'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r     <= DS_IDLE;
      cnt_r    <= 4'h0;
      sr_r     <= 8'h00;
      idx_r    <= 2'd0;
      rw_r     <= 1'b0;
      oe_r     <= 1'b0;
      hi_r     <= 8'h00;
      ptr_r    <= 4'h0;
      wr_en_r  <= 1'b0;
      wr_val_r <= 16'h0000;
    end else begin
      wr_en_r <= 1'b0;
      if (start_det) begin
        st_r  <= DS_RX;
        cnt_r <= 4'h0;
        idx_r <= 2'd0;
        oe_r  <= 1'b0;
      end else if (stop_det || bus_idle_timeout) begin
        st_r <= DS_IDLE;
        oe_r <= 1'b0;
      end else begin
        case (st_r)
          DS_RX: begin
            if (scl_rise) begin
              sr_r  <= {sr_r[6:0], sda_s[1]};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == 4'h8) begin
              if (idx_r == 2'd0) begin
                if (sr_r[7:1] == {ADDR_PREFIX, asel_s2}) begin
                  rw_r <= sr_r[0];
                  oe_r <= 1'b1;
                  st_r <= DS_RXACK;
                end else begin
                  st_r <= DS_IDLE;
                end
              end else if (ack_ok) begin
                oe_r <= 1'b1;
                st_r <= DS_RXACK;
                if (idx_r == 2'd1) begin
                  ptr_r <= sr_r[3:0];
                end else if (idx_r == 2'd2 && ptr_r != PTR_RES) begin
                  hi_r <= sr_r;
                end else begin
                  wr_en_r  <= 1'b1;
                  wr_val_r <= (ptr_r == PTR_RES) ? {8'h00, sr_r} : {hi_r, sr_r};
                end
              end else begin
                st_r <= DS_IDLE;
              end
            end
          end
          DS_RXACK: begin
            if (scl_fall) begin
              cnt_r <= 4'h0;
              idx_r <= idx_r + 2'd1;
              if (rw_r) begin
                sr_r <= nxt_byte;
                oe_r <= ~nxt_byte[7];
                st_r <= DS_TX;
              end else begin
                oe_r <= 1'b0;
                st_r <= DS_RX;
              end
            end
          end
          DS_TX: begin
            if (scl_fall) begin
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == 4'h7) begin
                oe_r <= 1'b0;
                st_r <= DS_TXACK;
              end else begin
                sr_r <= {sr_r[6:0], 1'b0};
                oe_r <= ~sr_r[6];
              end
            end
          end
          DS_TXACK: begin
            if (scl_rise && sda_s[1]) begin
              st_r <= DS_IDLE;
            end else if (scl_fall) begin
              cnt_r <= 4'h0;
              idx_r <= (idx_r == 2'd3) ? idx_r : idx_r + 2'd1;
              sr_r  <= nxt_byte;
              oe_r  <= ~nxt_byte[7];
              st_r  <= DS_TX;
            end
          end
          default: begin
            oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  assign link.sda_o_d  = 1'b0;
  assign link.sda_oe_d = oe_r;

endmodule : tss_dev

/* design/tss_host.sv */
`timescale 1ns/1ns
module tss_host
  import tss_pkg::*;
#(
  parameter int unsigned QTR_CYC = QTR_CYC_DEF
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Serial link
  tss_link_if.host         link
);

  // ----------------------------------------------------------------
  // Bus slave and registers
  // ----------------------------------------------------------------
  logic [1:0]  sda_s;
  logic        wph_r;
  logic [7:0]  wad_r;
  logic [6:0]  dadr_r;
  logic        rw_r;
  logic [1:0]  nb_r;
  logic [7:0]  ptr_r;
  logic [15:0] wdat_r;
  logic [15:0] rdat_r;
  logic        nack_r;
  logic        go;
  tss_hst_t    st_r;
  logic        busy;
  logic        aph;
  logic        hold_free;

  // Busy spans the bus-free gap, so no command can start inside it
  assign busy      = (st_r != HS_IDLE) || hold_free;
  assign aph       = hsel & hready & htrans[1];
  assign go        = wph_r && wad_r == HR_CMD && !busy;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph_r  <= 1'b0;
      wad_r  <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      wph_r <= aph & hwrite;
      wad_r <= haddr[7:0];
      if (aph && !hwrite) begin
        case (haddr[7:0])
          HR_CMD:   hrdata <= {22'h0, nb_r, rw_r, dadr_r};
          HR_PTR:   hrdata <= {24'h0, ptr_r};
          HR_WDATA: hrdata <= {16'h0, wdat_r};
          HR_STAT:  hrdata <= {30'h0, nack_r, busy};
          HR_RDATA: hrdata <= {16'h0, rdat_r};
          default:  hrdata <= 32'h0;
        endcase
      end
    end
  end

  // Command fields stay frozen while a transfer runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dadr_r <= 7'h00;
      rw_r   <= 1'b0;
      nb_r   <= 2'd0;
      ptr_r  <= 8'h00;
      wdat_r <= 16'h0000;
    end else if (wph_r && !busy) begin
      case (wad_r)
        HR_CMD: begin
          dadr_r <= hwdata[6:0];
          rw_r   <= hwdata[CMD_RW];
          nb_r   <= hwdata[CMD_NB_LSB +: 2];
        end
        HR_PTR:   ptr_r  <= {4'h0, hwdata[3:0]};
        HR_WDATA: wdat_r <= hwdata[15:0];
        default:  ptr_r  <= ptr_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  logic [12:0] qcnt_r;
  logic [1:0]  ph_r;
  logic [3:0]  bitn_r;
  logic [1:0]  byten_r;
  logic [7:0]  sr_r;
  logic        scl_oe_r;
  logic        sda_oe_r;
  logic        tick;
  logic [1:0]  last;
  logic        is_tx;
  logic [7:0]  txb;
  logic [1:0]  nxt;

  assign tick  = (qcnt_r == 13'(QTR_CYC - 1));
  assign last  = rw_r ? nb_r : nb_r + 2'd1;
  assign is_tx = (byten_r == 2'd0) || !rw_r;
  assign nxt   = byten_r + 2'd1;

  always_comb begin
    case (nxt)
      2'd1:    txb = ptr_r;
      2'd2:    txb = (nb_r == 2'd2) ? wdat_r[15:8] : wdat_r[7:0];
      default: txb = wdat_r[7:0];
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_s <= 2'h3;
    end else begin
      sda_s <= {sda_s[0], link.sda};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qcnt_r <= 13'h0;
    end else if (st_r == HS_IDLE || tick) begin
      qcnt_r <= 13'h0;
    end else begin
      qcnt_r <= qcnt_r + 13'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r     <= HS_IDLE;
      ph_r     <= 2'd0;
      bitn_r   <= 4'h0;
      byten_r  <= 2'd0;
      sr_r     <= 8'h00;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      nack_r   <= 1'b0;
      rdat_r   <= 16'h0000;
    end else if (go) begin
      st_r   <= HS_START;
      ph_r   <= 2'd0;
      nack_r <= 1'b0;
      rdat_r <= 16'h0000;
    end else if (tick) begin
      ph_r <= ph_r + 2'd1;
      case (st_r)
        HS_START: begin
          if (ph_r == 2'd1) sda_oe_r <= 1'b1;
          if (ph_r == 2'd2) scl_oe_r <= 1'b1;
          if (ph_r == 2'd3) begin
            st_r    <= HS_BIT;
            bitn_r  <= 4'h0;
            byten_r <= 2'd0;
            sr_r    <= {dadr_r, rw_r};
          end
        end
        HS_BIT: begin
          case (ph_r)
            2'd0: begin
              if (bitn_r != 4'h8) begin
                sda_oe_r <= is_tx & ~sr_r[7];
              end else begin
                sda_oe_r <= !is_tx && byten_r != last;
              end
            end
            2'd1: scl_oe_r <= 1'b0;
            2'd2: begin
              if (bitn_r != 4'h8) begin
                if (!is_tx) sr_r <= {sr_r[6:0], sda_s[1]};
              end else if (is_tx && sda_s[1]) begin
                nack_r <= 1'b1;
              end
            end
            default: begin
              scl_oe_r <= 1'b1;
              bitn_r   <= bitn_r + 4'h1;
              if (bitn_r != 4'h8) begin
                if (is_tx) sr_r <= {sr_r[6:0], 1'b0};
              end else begin
                bitn_r <= 4'h0;
                if (!is_tx) rdat_r <= {rdat_r[7:0], sr_r};
                if (nack_r || byten_r == last) begin
                  st_r <= HS_STOP;
                end else begin
                  byten_r <= nxt;
                  sr_r    <= txb;
                end
              end
            end
          endcase
        end
        HS_STOP: begin
          if (ph_r == 2'd0) sda_oe_r <= 1'b1;
          if (ph_r == 2'd1) scl_oe_r <= 1'b0;
          if (ph_r == 2'd2) sda_oe_r <= 1'b0;
          if (ph_r == 2'd3) begin
            st_r   <= HS_FREE;
            bitn_r <= 4'h0;
          end
        end
        HS_FREE: begin
          if (ph_r == 2'd3) begin
            st_r <= HS_IDLE;
          end
        end
        default: st_r <= HS_IDLE;
      endcase
    end
  end

  // Bus-free wait: the longer of a full idle bit and the counted gap
  logic [15:0] free_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      free_r <= 16'h0;
    end else if (st_r == HS_STOP) begin
      free_r <= 16'(BUS_FREE_CYC);
    end else if (free_r != 16'h0) begin
      free_r <= free_r - 16'h1;
    end
  end

  assign hold_free = (free_r != 16'h0) && st_r == HS_IDLE;

  assign link.scl_o_h  = 1'b0;
  assign link.scl_oe_h = scl_oe_r;
  assign link.sda_o_h  = 1'b0;
  assign link.sda_oe_h = sda_oe_r;

endmodule : tss_host

/* tb/tss_checker.sv */
`timescale 1ns/1ns
module tss_checker #(
  parameter int QTR_CYC  = 8,
  parameter int FREE_CYC = 250
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Wired link
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_oe_d,
  input wire logic evt_oe_d
);
  logic [15:0] lo_cnt_r;
  logic        sda_q;
  logic [15:0] free_cnt_r;
  default clocking cb @(posedge hclk); endclocking
  // Cycles since the last stop, saturating; full after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_q      <= 1'b1;
      free_cnt_r <= 16'hFFFF;
    end else begin
      sda_q <= sda;
      if (sda && !sda_q && scl) begin
        free_cnt_r <= 16'h0000;
      end else if (free_cnt_r != 16'hFFFF) begin
        free_cnt_r <= free_cnt_r + 16'h0001;
      end
    end
  end
  default disable iff (!hresetn);
  // Length of the current clock-low stretch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lo_cnt_r <= 16'h0000;
    end else begin
      lo_cnt_r <= scl ? 16'h0000 : lo_cnt_r + 16'h0001;
    end
  end
  a_start_release: assert property ($fell(sda) && scl |-> !sda_oe_d [*8])
    else $error("device holds data after start");
  a_stop_free: assert property ($rose(sda) && scl |-> (sda && scl && !sda_oe_d) [*8])
    else $error("bus not free after stop");
  a_drive_low: assert property ($rose(sda_oe_d) |-> !scl)
    else $error("device drive begins with clock high");
  a_ack_fall: assert property ($fell(scl) && sda_oe_d |-> sda_oe_d [*2])
    else $error("device drop at clock fall");
  a_hold_high: assert property (scl && sda_oe_d |=> sda_oe_d || !scl)
    else $error("device drop while clock high");
  a_start_clock: assert property ($fell(sda) && scl |-> ##[1:100] !scl)
    else $error("no clock after start");
  a_clk_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high too short");
  a_clk_low_bound: assert property (lo_cnt_r <= 16'(4 * QTR_CYC))
    else $error("clock held low too long");
  a_bus_free: assert property ($fell(sda) && scl |-> free_cnt_r >= 16'(FREE_CYC))
    else $error("start inside bus-free gap");
  c_start: cover property ($fell(sda) && scl);
  c_ack: cover property ($rose(sda_oe_d));
  c_evt: cover property ($rose(evt_oe_d));
endmodule : tss_checker

/* tb/tss_tb_top.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tss_tb_top
  import tss_pkg::*;
;
  localparam int         QTR   = 8;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [6:0] DA    = {ADDR_PREFIX, STRAP};
  localparam logic [6:0] DB    = {ADDR_PREFIX, ~STRAP};
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        conv_done;
  logic [12:0] conv_temp;
  logic [2:0]  strap;
  int          failures;
  int          n_checks;
  tss_link_if  lk ();
  tss_link_if  l2 ();
  tss_host #(.QTR_CYC(QTR)) u_tss_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(lk));
  tss_dev #(.BUS_IDLE_TIMEOUT_CYC(2000)) u_tss_dev (.hclk(hclk), .hresetn(hresetn), .link(lk),
    .addr_sel_bit0(strap[0]), .addr_sel_bit1(strap[1]), .addr_sel_bit2(strap[2]),
    .conv_done(conv_done), .conv_temp(conv_temp));
  // Second device, clocked by hand to break the bus rules
  tss_dev #(.BUS_IDLE_TIMEOUT_CYC(200)) u_tss_dev_b (.hclk(hclk), .hresetn(hresetn), .link(l2),
    .addr_sel_bit0(~strap[0]), .addr_sel_bit1(~strap[1]), .addr_sel_bit2(~strap[2]),
    .conv_done(conv_done), .conv_temp(conv_temp));
  tss_checker #(.QTR_CYC(QTR), .FREE_CYC(BUS_FREE_CYC)) u_tss_checker (.hclk(hclk),
    .hresetn(hresetn),
    .scl(lk.scl), .sda(lk.sda), .sda_oe_d(lk.sda_oe_d), .evt_oe_d(lk.evt_oe_d));
  always #(CLK_NS / 2) hclk = ~hclk;
  // ----
  // Bus and link tasks
  // ----
  task automatic end_of_test();
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask : ahb
  task automatic run(input logic rw, input logic [1:0] n, input logic [6:0] ad,
                     output logic nk);
    logic [31:0] r;
    ahb(1'h1, HR_CMD, {22'h0, n, rw, ad}, r);
    for (int k = 0; k < 2000; k++) begin
      ahb(1'h0, HR_STAT, 32'h0, r);
      if (r[STAT_BUSY] === 1'h0) break;
    end
    `CHK(r[STAT_BUSY], 1'h0)
    nk = r[STAT_NACK];
  endtask : run
  task automatic wr_reg(input logic [3:0] p, input logic [1:0] n, input logic [15:0] d);
    logic [31:0] r;
    logic        nk;
    ahb(1'h1, HR_PTR, {28'h0, p}, r);
    ahb(1'h1, HR_WDATA, {16'h0, d}, r);
    run(1'h0, n, DA, nk);
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] p, input logic [1:0] n, output logic [15:0] v);
    logic [31:0] r;
    logic        nk;
    ahb(1'h1, HR_PTR, {28'h0, p}, r);
    run(1'h0, 2'h0, DA, nk);
    `CHK(nk, 1'h0)
    run(1'h1, n, DA, nk);
    `CHK(nk, 1'h0)
    ahb(1'h0, HR_RDATA, 32'h0, r);
    v = r[15:0];
  endtask : rd_reg
  task automatic conv(input logic [12:0] t);
    @(posedge hclk);
    conv_done <= 1'h1;
    conv_temp <= t;
    @(posedge hclk);
    conv_done <= 1'h0;
  endtask : conv
  // One quarter of a hand-made bit
  task automatic q(input logic c, input logic d);
    @(posedge hclk);
    l2.scl_oe_h <= ~c;
    l2.sda_oe_h <= ~d;
    repeat (QTR - 1) @(posedge hclk);
  endtask : q
  task automatic xb(input logic [7:0] o, input logic a, output logic [7:0] i,
                    output logic ak);
    for (int k = 7; k >= 0; k--) begin
      q(1'h0, o[k]);
      q(1'h1, o[k]);
      i[k] = l2.sda;
      q(1'h1, o[k]);
      q(1'h0, o[k]);
    end
    q(1'h0, a);
    q(1'h1, a);
    ak = l2.sda;
    q(1'h1, a);
    q(1'h0, a);
  endtask : xb
  task automatic start();
    q(1'h1, 1'h1);
    q(1'h1, 1'h0);
    q(1'h0, 1'h0);
  endtask : start
  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    logic [15:0] ev [9] = '{CAP_DEF, CFG_RST, LIMIT_RST, LIMIT_RST, LIMIT_RST,
                            16'hC190, MAKER_ID_DEF, DEV_ID_DEF, {8'h00, RES_RST}};
    logic [15:0] v;
    logic [31:0] r;
    logic        nk;
    conv(13'h0190);
    // Codes 9 to F stay untouched
    for (int p = 0; p < 9; p++) begin
      rd_reg(4'(p), (p == 8) ? 2'h1 : 2'h2, v);
      `CHK(v, ev[p])
    end
    run(1'h1, 2'h1, DA, nk);
    ahb(1'h0, HR_RDATA, 32'h0, r);
    `CHK(r[15:0], {8'h00, RES_RST})
  endtask : t_regs
  task automatic t_limits();
    logic [15:0] v;
    wr_reg(PTR_UPPER, 2'h2, 16'hFFFF);
    rd_reg(PTR_UPPER, 2'h2, v);
    `CHK(v, 16'hFFFF & LIMIT_MASK)
    wr_reg(PTR_TEMP, 2'h2, 16'h0000);
    rd_reg(PTR_TEMP, 2'h2, v);
    `CHK(v, 16'hC190)
    wr_reg(PTR_CFG, 2'h2, 16'(1 << CFG_EVT_EN));
    repeat (4) @(posedge hclk);
    `CHK(lk.evt_n, 1'h0)
    wr_reg(PTR_UPPER, 2'h2, 16'h0FFC);
    wr_reg(PTR_CRIT, 2'h2, 16'h0FFC);
    conv(13'h0191);
    rd_reg(PTR_TEMP, 2'h2, v);
    `CHK(v, 16'h0191)
    `CHK(lk.evt_n, 1'h1)
    wr_reg(PTR_RES, 2'h1, 16'h0003);
    rd_reg(PTR_RES, 2'h1, v);
    `CHK(v, 16'h0003)
  endtask : t_limits
  task automatic t_addr();
    logic [6:0]  bad [4] = '{7'h1C, 7'h3D, 7'h5D, 7'h19};
    logic [31:0] r;
    logic        nk;
    foreach (bad[i]) begin
      run(i[0], 2'h1, bad[i], nk);
      `CHK(nk, 1'h1)
    end
    run(1'h1, 2'h1, DA, nk);
    `CHK(nk, 1'h0)
    ahb(1'h0, HR_CMD, 32'h0, r);
    `CHK(r, {22'h0, 2'h1, 1'h1, DA})
    ahb(1'h0, HR_PTR, 32'h0, r);
    `CHK(r, {24'h0, 4'h0, PTR_RES})
    ahb(1'h0, 8'h20, 32'h0, r);
    `CHK(r, 32'h0)
    `CHK(hresp, 1'h0)
  endtask : t_addr
  task automatic t_link2();
    logic [7:0] b;
    logic       ak;
    start();
    xb({DB, 1'h0}, 1'h1, b, ak);
    `CHK(ak, 1'h0)
    for (int k = 0; k < 4; k++) begin
      q(1'h0, 1'h1);
      q(1'h1, 1'h1);
      q(1'h1, 1'h1);
      q(1'h0, 1'h1);
    end
    // Restart in mid-byte
    start();
    xb({DB, 1'h1}, 1'h1, b, ak);
    `CHK(ak, 1'h0)
    xb(8'hFF, 1'h0, b, ak);
    `CHK(b, CAP_DEF[15:8])
    q(1'h0, 1'h1);
    `CHK(l2.sda, CAP_DEF[7])
    repeat (40) q(1'h0, 1'h1);
    `CHK(l2.sda, 1'h1)
    q(1'h0, 1'h0);
    q(1'h1, 1'h0);
    q(1'h1, 1'h1);
    repeat (BUS_FREE_CYC) @(posedge hclk);
    start();
    xb({DA, 1'h0}, 1'h1, b, ak);
    `CHK(ak, 1'h1)
  endtask : t_link2
  initial begin
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata, conv_done, conv_temp} = '0;
    {l2.scl_o_h, l2.sda_o_h, l2.scl_oe_h, l2.sda_oe_h} = 4'h0;
    hsize = 3'h2;
    strap = STRAP;
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (3) @(posedge hclk);
    t_regs();
    t_limits();
    t_addr();
    t_link2();
    end_of_test();
  end
  initial begin
    #1800000;
    failures++;
    end_of_test();
  end
endmodule : tss_tb_top
